/* File: logic/sltb_defs.vh */
`ifndef SLTB_DEFS_VH
`define SLTB_DEFS_VH

// ------------------------------------------------------------
// register indices (byte address is four times the index)
// ------------------------------------------------------------
`define SLTB_IDX_MISC_OPTION 8'h94
`define SLTB_IDX_INT_FLAGS 8'h95
`define SLTB_IDX_PIN_MODE_CTRL 8'hA6
`define SLTB_IDX_T2_RELOAD_LO 8'hCA
`define SLTB_IDX_T2_RELOAD_HI 8'hCB
`define SLTB_IDX_T2_COUNT_LO 8'hCC
`define SLTB_IDX_T2_COUNT_HI 8'hCD
`define SLTB_IDX_IRQ_STATUS 8'hE0
`define SLTB_IDX_IRQ_MASK 8'hE1
`define SLTB_IDX_AUX_CTRL 8'hF8

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define SLTB_RATE_SEL_LO 0
`define SLTB_RATE_SEL_HI 1
`define SLTB_TB_FLAG_BIT 0
`define SLTB_T0_WAVE_EN_BIT 0
`define SLTB_T2_WAVE_EN_BIT 4
`define SLTB_TB_CLEAR_BIT 6
`define SLTB_EV_TB_BIT 0
`define SLTB_EV_T0_BIT 1
`define SLTB_EV_T2_BIT 2
`define SLTB_EV_NUM 3

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define SLTB_RST_BYTE 8'h00
`define SLTB_RST_EV 3'h0

// ------------------------------------------------------------
// timing counts, in slow-clock cycles and overflow pulses
// ------------------------------------------------------------
`define SLTB_TB_PER_00 16'h8000
`define SLTB_TB_PER_01 16'h4000
`define SLTB_TB_PER_10 16'h2000
`define SLTB_TB_PER_11 16'h0080
`define SLTB_T0_DIV_HALF 6'h20
`define SLTB_T2_DIV_HALF 6'h01

`endif

/* File: logic/sltb_top.v */
// Operation
// - time base counts edges of the chosen slow clock, rc or crystal
// - rate code 00/01/10/11 gives 32768/16384/8192/128 slow cycles
// - each completed period sets the time-base flag, int_flags bit 0
// - entering the time-base service routine clears the flag
// - writing FEh to int_flags clears the time-base flag
// - tb_clear restarts the counter and drops back to 0 next cycle
// - first buzzer wave is timer0 overflow divided by 64
// - second buzzer wave is timer2 overflow divided by 2
// - t2_wave_en (pin mode bit 4) routes the timer2 wave to P1.0
// - t0_wave_en (pin mode bit 0) routes the timer0 wave to P3.4
// - timer2 count low and high bytes, read/write, reset to zero
// - timer2 reload low and high bytes, read/write, reset to zero
`include "sltb_defs.vh"

module sltb_top (
    input wire i_clk,
    input wire i_rst,
    input wire i_ce,
    // apb slave
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [11:0] i_paddr,
    input wire [31:0] i_pwdata,
    output reg [31:0] o_prdata,
    output wire o_pready,
    output reg o_pslverr,
    // slow clock sources and selection
    input wire i_slow_rc_osc,
    input wire i_slow_crystal_osc,
    input wire i_slow_src_sel,
    // processor enters the time-base service routine
    input wire i_tb_isr_enter,
    // timer overflow pulses
    input wire i_t0_ovf,
    input wire i_t2_ovf,
    // buzzer pins
    output reg o_t0_wave_out,
    output wire o_t0_wave_en,
    output reg o_t2_wave_out,
    output wire o_t2_wave_en,
    // timer2 byte registers toward the timer2 core
    output wire [15:0] o_t2_count,
    output wire [15:0] o_t2_reload,
    // time-base flag and interrupt
    output wire o_tb_flag,
    output wire o_irq
);

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------

    // period length for a rate code
    function [15:0] sltb_period;
        input [1:0] sel;
        begin
            case (sel)
                2'b00: sltb_period = `SLTB_TB_PER_00;
                2'b01: sltb_period = `SLTB_TB_PER_01;
                2'b10: sltb_period = `SLTB_TB_PER_10;
                default: sltb_period = `SLTB_TB_PER_11;
            endcase
        end
    endfunction

    // word index of an address, or zero when misaligned or out of range
    function [8:0] sltb_decode;
        input [11:0] addr;
        begin
            if (addr[1:0] != 2'b00 || addr[11:10] != 2'b00) begin
                sltb_decode = 9'h000;
            end else begin
                sltb_decode = {1'b1, addr[9:2]};
            end
        end
    endfunction

    // write strobe for one register index; the int_flags, aux control and irq status writers share this decode
    function sltb_wr_hit;
        input go;
        input hit;
        input [7:0] idx;
        input [7:0] want;
        begin
            sltb_wr_hit = go & hit & (idx == want);
        end
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    reg [7:0] misc_option;
    reg tb_flag;
    reg [7:0] pin_mode_ctrl;
    reg [7:0] t2_reload_lo;
    reg [7:0] t2_reload_hi;
    reg [7:0] t2_count_lo;
    reg [7:0] t2_count_hi;
    reg [7:0] aux_ctrl;
    reg [2:0] irq_status;
    reg [2:0] irq_mask;
    reg rd_ready;
    reg [15:0] tb_count;
    reg slow_prev;
    reg [5:0] t0_div;
    reg [5:0] t2_div;

    wire [8:0] dec;
    wire dec_hit;
    wire [7:0] dec_idx;
    wire setup_go;
    wire access_go;
    wire wr_go;
    wire slow_src;
    wire slow_edge;
    wire [15:0] tb_last;
    wire tb_done;
    wire tb_restart;
    wire t0_toggle;
    wire t2_toggle;
    wire [2:0] ev;
    wire wr_int_flags;
    wire wr_aux_ctrl;
    wire wr_irq_status;
    reg [31:0] next_prdata;
    reg next_pslverr;

    // ------------------------------------------------------------
    // apb handshake
    // ------------------------------------------------------------

    // zero wait states while i_ce is high; a low i_ce holds pready
    // low, so a master waits; if i_ce is low in the setup cycle, pready never rises
    // errors are judged in setup from the address alone; an errored
    // write changes nothing
    // unused data bits of every register read back as zero
    // data is fetched in setup, so access completes in its first cycle
    assign o_pready = rd_ready & i_ce;
    assign setup_go = i_psel & ~i_penable & i_ce;
    assign access_go = i_psel & i_penable & o_pready;
    assign wr_go = access_go & i_pwrite;
    assign dec = sltb_decode(i_paddr);
    assign dec_hit = dec[8];
    assign dec_idx = dec[7:0];

    // per-register write strobes, only on the completing access edge
    assign wr_int_flags = sltb_wr_hit(wr_go, dec_hit, dec_idx, `SLTB_IDX_INT_FLAGS);
    assign wr_aux_ctrl = sltb_wr_hit(wr_go, dec_hit, dec_idx, `SLTB_IDX_AUX_CTRL);
    assign wr_irq_status = sltb_wr_hit(wr_go, dec_hit, dec_idx, `SLTB_IDX_IRQ_STATUS);

    // every register is at most one byte wide, so upper data bits read zero
    // read mux and unmapped-address check
    always @* begin
        next_prdata = 32'h0000_0000;
        next_pslverr = 1'b0;
        if (!dec_hit) begin
            next_pslverr = 1'b1;
        end else begin
            case (dec_idx)
                `SLTB_IDX_MISC_OPTION: next_prdata[7:0] = misc_option;
                `SLTB_IDX_INT_FLAGS: next_prdata[`SLTB_TB_FLAG_BIT] = tb_flag;
                `SLTB_IDX_PIN_MODE_CTRL: next_prdata[7:0] = pin_mode_ctrl;
                `SLTB_IDX_T2_RELOAD_LO: next_prdata[7:0] = t2_reload_lo;
                `SLTB_IDX_T2_RELOAD_HI: next_prdata[7:0] = t2_reload_hi;
                `SLTB_IDX_T2_COUNT_LO: next_prdata[7:0] = t2_count_lo;
                `SLTB_IDX_T2_COUNT_HI: next_prdata[7:0] = t2_count_hi;
                `SLTB_IDX_IRQ_STATUS: next_prdata[2:0] = irq_status;
                `SLTB_IDX_IRQ_MASK: next_prdata[2:0] = irq_mask;
                `SLTB_IDX_AUX_CTRL: next_prdata[7:0] = aux_ctrl;
                default: next_pslverr = 1'b1;
            endcase
        end
    end

    // read data captured in setup; held through the access phase
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_prdata <= 32'h0000_0000;
            o_pslverr <= 1'b0;
            rd_ready <= 1'b0;
        end else if (i_ce) begin
            if (setup_go) begin
                o_prdata <= i_pwrite ? 32'h0000_0000 : next_prdata;
                o_pslverr <= next_pslverr;
                rd_ready <= 1'b1;
            end else if (access_go) begin
                rd_ready <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // plain read/write registers
    // ------------------------------------------------------------

    // timer2 bytes are plain storage here; the timer2 core loads them
    // an errored write stores nothing: dec_hit gates it out, or the default item holds irq_mask
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            misc_option <= `SLTB_RST_BYTE;
            pin_mode_ctrl <= `SLTB_RST_BYTE;
            t2_reload_lo <= `SLTB_RST_BYTE;
            t2_reload_hi <= `SLTB_RST_BYTE;
            t2_count_lo <= `SLTB_RST_BYTE;
            t2_count_hi <= `SLTB_RST_BYTE;
            irq_mask <= `SLTB_RST_EV;
        end else if (i_ce && wr_go && dec_hit) begin
            case (dec_idx)
                `SLTB_IDX_MISC_OPTION: misc_option <= i_pwdata[7:0];
                `SLTB_IDX_PIN_MODE_CTRL: pin_mode_ctrl <= i_pwdata[7:0];
                `SLTB_IDX_T2_RELOAD_LO: t2_reload_lo <= i_pwdata[7:0];
                `SLTB_IDX_T2_RELOAD_HI: t2_reload_hi <= i_pwdata[7:0];
                `SLTB_IDX_T2_COUNT_LO: t2_count_lo <= i_pwdata[7:0];
                `SLTB_IDX_T2_COUNT_HI: t2_count_hi <= i_pwdata[7:0];
                `SLTB_IDX_IRQ_MASK: irq_mask <= i_pwdata[2:0];
                default: irq_mask <= irq_mask;
            endcase
        end
    end

    assign o_t2_count = {t2_count_hi, t2_count_lo};
    assign o_t2_reload = {t2_reload_hi, t2_reload_lo};

    // other aux bits are stored only; their functions live elsewhere
    // aux control; the clear bit only lives for one cycle
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            aux_ctrl <= `SLTB_RST_BYTE;
        end else if (i_ce) begin
            if (wr_aux_ctrl) begin
                aux_ctrl <= i_pwdata[7:0];
            end else begin
                aux_ctrl[`SLTB_TB_CLEAR_BIT] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // time base
    // ------------------------------------------------------------

    // slow sources are levels sampled by i_clk, not clocks of their own:
    // one domain for count, flag, clear bit and bus, so no crossing
    // limitation: a slow clock near half of i_clk loses edges
    // only rising edges advance the count; a stuck-high source
    // freezes the period instead of running it on
    // the rate field is read live, never latched at period start
    // switching source mid-period may add one spurious edge; harmless
    assign slow_src = i_slow_src_sel ? i_slow_crystal_osc : i_slow_rc_osc;
    assign slow_edge = slow_src & ~slow_prev;
    assign tb_last = sltb_period(misc_option[`SLTB_RATE_SEL_HI:`SLTB_RATE_SEL_LO]) - 16'h0001;
    assign tb_restart = aux_ctrl[`SLTB_TB_CLEAR_BIT];
    // a shorter rate picked mid-count wraps at once, not after 64k edges
    assign tb_done = slow_edge & ~tb_restart & (tb_count >= tb_last);

    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            slow_prev <= 1'b0;
            tb_count <= 16'h0000;
        end else if (i_ce) begin
            slow_prev <= slow_src;
            if (tb_restart) begin
                tb_count <= 16'h0000;
            end else if (tb_done) begin
                tb_count <= 16'h0000;
            end else if (slow_edge) begin
                tb_count <= tb_count + 16'h0001;
            end
        end
    end

    // priority: period end, then service entry, then a bus write;
    // a lost period end would stretch the next interval to two
    // flag: a period end beats a clear in the same cycle
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            tb_flag <= 1'b0;
        end else if (i_ce) begin
            if (tb_done) begin
                tb_flag <= 1'b1;
            end else if (i_tb_isr_enter) begin
                tb_flag <= 1'b0;
            end else if (wr_int_flags) begin
                tb_flag <= i_pwdata[`SLTB_TB_FLAG_BIT];
            end
        end
    end

    assign o_tb_flag = tb_flag;

    // ------------------------------------------------------------
    // buzzer dividers
    // ------------------------------------------------------------
    assign o_t0_wave_en = pin_mode_ctrl[`SLTB_T0_WAVE_EN_BIT];
    assign o_t2_wave_en = pin_mode_ctrl[`SLTB_T2_WAVE_EN_BIT];
    assign t0_toggle = o_t0_wave_en & i_t0_ovf & (t0_div == `SLTB_T0_DIV_HALF - 6'h01);
    assign t2_toggle = o_t2_wave_en & i_t2_ovf & (t2_div == `SLTB_T2_DIV_HALF - 6'h01);

    // both dividers count overflow pulses, never clock cycles
    // the timer cores outside own the reload speed, so the wave
    // frequency follows whatever reload software programs
    // disabling rewinds a divider: a re-enabled wave starts low
    // and always gives a full half period before its first rise
    // one overflow per cycle at most; a faster burst
    // would be seen as a single pulse
    // toggling every half period of overflows keeps a 50% square wave
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            t0_div <= 6'h00;
            o_t0_wave_out <= 1'b0;
        end else if (i_ce) begin
            if (!o_t0_wave_en) begin
                t0_div <= 6'h00;
                o_t0_wave_out <= 1'b0;
            end else if (t0_toggle) begin
                t0_div <= 6'h00;
                o_t0_wave_out <= ~o_t0_wave_out;
            end else if (i_t0_ovf) begin
                t0_div <= t0_div + 6'h01;
            end
        end
    end

    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            t2_div <= 6'h00;
            o_t2_wave_out <= 1'b0;
        end else if (i_ce) begin
            if (!o_t2_wave_en) begin
                t2_div <= 6'h00;
                o_t2_wave_out <= 1'b0;
            end else if (t2_toggle) begin
                t2_div <= 6'h00;
                o_t2_wave_out <= ~o_t2_wave_out;
            end else if (i_t2_ovf) begin
                t2_div <= t2_div + 6'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // interrupt status and mask
    // ------------------------------------------------------------

    // own status and mask pair beside the time-base flag, so buzzer
    // edges can wake software without polling the pins
    // the time-base flag keeps its own clear paths; clearing the
    // status bit here leaves it untouched, and the other way round
    // one level output: high while any unmasked status bit is set
    // events: period end, and rising edges of each buzzer wave
    assign ev = {t2_toggle & ~o_t2_wave_out, t0_toggle & ~o_t0_wave_out, tb_done};

    // write one to clear; a new event in the same cycle survives
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            irq_status <= `SLTB_RST_EV;
        end else if (i_ce) begin
            if (wr_irq_status) begin
                irq_status <= (irq_status & ~i_pwdata[2:0]) | ev;
            end else begin
                irq_status <= irq_status | ev;
            end
        end
    end

    assign o_irq = |(irq_status & irq_mask);

endmodule

/* File: testbench/sltb_monitor.sv */
module sltb_monitor (
    input wire i_clk,
    input wire i_rst,
    input wire i_ce,
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [11:0] i_paddr,
    input wire [31:0] i_pwdata,
    input wire o_pready,
    input wire i_slow_rc_osc,
    input wire i_slow_crystal_osc,
    input wire i_slow_src_sel,
    input wire i_tb_isr_enter,
    input wire i_t0_ovf,
    input wire i_t2_ovf,
    input wire o_t0_wave_out,
    input wire o_t0_wave_en,
    input wire o_t2_wave_out,
    input wire o_t2_wave_en,
    input wire o_tb_flag
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking dc @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // ----------
    // helpers
    // ----------
    wire slow_now = i_slow_src_sel ? i_slow_crystal_osc : i_slow_rc_osc;
    reg wr_q;
    reg [4:0] t0_cnt;
    // mirror of the t0 count; wraps at 32 so no compare is needed
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wr_q <= 1'h0;
            t0_cnt <= 5'h00;
        end else begin
            wr_q <= i_psel & i_penable & o_pready & i_pwrite;
            if (!o_t0_wave_en)
                t0_cnt <= 5'h00;
            else if (i_t0_ovf && i_ce)
                t0_cnt <= t0_cnt + 5'h01;
        end
    end
    sequence s_fe_write;
        i_psel && i_penable && o_pready && i_pwrite && i_paddr == 12'h254 && !i_pwdata[0];
    endsequence
    // a slow edge may end a period and win over any clear
    sequence s_slow_quiet;
        !$rose(slow_now);
    endsequence
    // ----------
    // assertions
    // ----------
    AST_T0_OFF: assert property (!o_t0_wave_en |=> !o_t0_wave_out)
        else $error("t0 wave high while disabled");
    AST_T2_OFF: assert property (!o_t2_wave_en |=> !o_t2_wave_out)
        else $error("t2 wave high while disabled");
    AST_T2_DIV: assert property (o_t2_wave_en && i_ce |=> o_t2_wave_out == ($past(o_t2_wave_out) ^ $past(i_t2_ovf)))
        else $error("t2 wave not toggling per overflow");
    AST_T0_TOG: assert property (o_t0_wave_en && i_ce && i_t0_ovf && t0_cnt == 5'h1F |=> $changed(o_t0_wave_out))
        else $error("t0 wave missed toggle on 32nd overflow");
    AST_T0_HOLD: assert property (o_t0_wave_en && !(i_ce && i_t0_ovf && t0_cnt == 5'h1F) |=> $stable(o_t0_wave_out))
        else $error("t0 wave toggled early");
    AST_ISR_CLR: assert property (i_tb_isr_enter && i_ce ##0 s_slow_quiet |=> !o_tb_flag)
        else $error("flag kept after service entry");
    AST_SW_CLR: assert property (s_fe_write ##0 s_slow_quiet |=> !o_tb_flag)
        else $error("flag kept after FEh write");
    AST_FLAG_SRC: assert property ($rose(o_tb_flag) |-> wr_q || ($past(slow_now) && !$past(slow_now, 2)))
        else $error("flag set without slow edge");
endmodule

bind sltb_top sltb_monitor i_mon (.i_clk, .i_rst, .i_ce, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
    .o_pready, .i_slow_rc_osc, .i_slow_crystal_osc, .i_slow_src_sel, .i_tb_isr_enter, .i_t0_ovf, .i_t2_ovf,
    .o_t0_wave_out, .o_t0_wave_en, .o_t2_wave_out, .o_t2_wave_en, .o_tb_flag);

/* File: testbench/sltb_buzzer_model.sv */
module sltb_buzzer_model (
    input wire i_clk,
    input wire i_rst,
    input wire i_t0_pin,
    input wire i_t0_en,
    input wire i_t2_pin,
    input wire i_t2_en,
    output int o_t0_rises,
    output int o_t2_rises
);
    timeunit 1ns;
    timeprecision 1ps;
    logic t0_q;
    logic t2_q;
    // the load only hears a pin that the block really drives
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            t0_q <= 1'h0;
            t2_q <= 1'h0;
            o_t0_rises <= 0;
            o_t2_rises <= 0;
        end else begin
            t0_q <= i_t0_pin & i_t0_en;
            t2_q <= i_t2_pin & i_t2_en;
            o_t0_rises <= o_t0_rises + int'(i_t0_pin & i_t0_en & !t0_q);
            o_t2_rises <= o_t2_rises + int'(i_t2_pin & i_t2_en & !t2_q);
        end
    end
endmodule

/* File: testbench/tb_top.sv */
`define CHK(n, x, g) begin checks++; if ((g) !== (x)) begin err_total++; $display("Error %s expected %0h seen %0h", n, x, g); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 1'h0, i_rst = 1'h1, i_ce = 1'h1, i_psel = 1'h0, i_penable = 1'h0, i_pwrite = 1'h0, re;
    logic i_slow_rc_osc = 1'h0, i_slow_crystal_osc = 1'h0, i_slow_src_sel = 1'h0, i_tb_isr_enter = 1'h0;
    logic i_t0_ovf = 1'h0, i_t2_ovf = 1'h0;
    logic [11:0] i_paddr = 12'h000;
    logic [31:0] i_pwdata = 32'h0, rq;
    wire [31:0] o_prdata;
    wire o_pready, o_pslverr, o_t0_wave_out, o_t0_wave_en, o_t2_wave_out, o_t2_wave_en, o_tb_flag, o_irq;
    wire [15:0] o_t2_count, o_t2_reload;
    int err_total = 0, checks = 0, r0, r2;
    always #2.5 i_clk = ~i_clk;
    sltb_top i_dut (.i_clk, .i_rst, .i_ce, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata,
        .o_pready, .o_pslverr, .i_slow_rc_osc, .i_slow_crystal_osc, .i_slow_src_sel, .i_tb_isr_enter, .i_t0_ovf,
        .i_t2_ovf, .o_t0_wave_out, .o_t0_wave_en, .o_t2_wave_out, .o_t2_wave_en, .o_t2_count, .o_t2_reload,
        .o_tb_flag, .o_irq);
    sltb_buzzer_model i_load (.i_clk, .i_rst, .i_t0_pin(o_t0_wave_out), .i_t0_en(o_t0_wave_en),
        .i_t2_pin(o_t2_wave_out), .i_t2_en(o_t2_wave_en), .o_t0_rises(r0), .o_t2_rises(r2));
    // ----------
    // bus and stimulus tasks
    // ----------
    // pready and data taken at the completing rising edge; the falling
    // edge after it lets the write settle before callers look
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge i_clk);
        i_psel <= 1'h1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'h1;
        @(posedge i_clk);
        while (o_pready !== 1'h1 && n < 64) begin
            n++;
            @(posedge i_clk);
        end
        if (n == 64) begin
            err_total++;
            tally_and_finish;
        end
        rq = o_prdata;
        re = o_pslverr;
        i_psel <= 1'h0;
        i_penable <= 1'h0;
        @(negedge i_clk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        apb(1'h0, a, 32'h0);
        `CHK("prdata", x, rq)
    endtask
    // m picks which oscillator line toggles: bit1 crystal, bit0 rc
    task automatic slow(input int n, input logic [1:0] m);
        repeat (n) begin
            @(posedge i_clk);
            {i_slow_crystal_osc, i_slow_rc_osc} <= m;
            @(posedge i_clk);
            {i_slow_crystal_osc, i_slow_rc_osc} <= 2'h0;
        end
        @(negedge i_clk);
    endtask
    task automatic pulse(input int n, input logic t2);
        repeat (n) begin
            @(posedge i_clk);
            {i_t2_ovf, i_t0_ovf} <= t2 ? 2'h2 : 2'h1;
            @(posedge i_clk);
            {i_t2_ovf, i_t0_ovf} <= 2'h0;
        end
        @(negedge i_clk);
    endtask
    // rate, counter restart and flag clear before every period test
    task automatic arm(input logic [1:0] c);
        apb(1'h1, 12'h250, {30'h0, c});
        apb(1'h1, 12'h3E0, 32'h40);
        apb(1'h1, 12'h254, 32'hFE);
    endtask
    task automatic done(input string s);
        $display("test %s finished, mismatches so far %0d", s, err_total);
    endtask
    // ----------
    // scenarios
    // ----------
    task automatic t_reset;
        logic [11:0] a[10] = '{12'h250, 12'h254, 12'h298, 12'h328, 12'h32C, 12'h330, 12'h334, 12'h380,
            12'h384, 12'h3E0};
        foreach (a[i]) rd(a[i], 32'h0);
        apb(1'h0, 12'h004, 32'h0);
        `CHK("unmapped err", 1'h1, re)
        apb(1'h1, 12'h332, 32'hFF);
        `CHK("misaligned err", 1'h1, re)
        rd(12'h330, 32'h0);
        done("reset");
    endtask
    task automatic t_regs;
        apb(1'h1, 12'h328, 32'hFFFF_FF11);
        apb(1'h1, 12'h32C, 32'h22);
        apb(1'h1, 12'h330, 32'h33);
        apb(1'h1, 12'h334, 32'h44);
        rd(12'h328, 32'h11);
        rd(12'h334, 32'h44);
        `CHK("reload", 16'h2211, o_t2_reload)
        `CHK("count", 16'h4433, o_t2_count)
        done("regs");
    endtask
    task automatic t_rates;
        arm(2'h3);
        slow(127, 2'h1);
        `CHK("flag c3 early", 1'h0, o_tb_flag)
        slow(1, 2'h1);
        `CHK("flag c3", 1'h1, o_tb_flag)
        rd(12'h254, 32'h1);
        arm(2'h2);
        slow(8191, 2'h1);
        `CHK("flag c2 early", 1'h0, o_tb_flag)
        slow(1, 2'h1);
        `CHK("flag c2", 1'h1, o_tb_flag)
        arm(2'h1);
        slow(16383, 2'h1);
        `CHK("flag c1 early", 1'h0, o_tb_flag)
        slow(1, 2'h1);
        `CHK("flag c1", 1'h1, o_tb_flag)
        arm(2'h0);
        slow(16384, 2'h1);
        `CHK("flag c0 early", 1'h0, o_tb_flag)
        done("rates");
    endtask
    task automatic t_source;
        @(posedge i_clk);
        i_slow_src_sel <= 1'h1;
        arm(2'h3);
        slow(200, 2'h1);
        `CHK("rc ignored", 1'h0, o_tb_flag)
        slow(128, 2'h2);
        `CHK("crystal flag", 1'h1, o_tb_flag)
        @(posedge i_clk);
        i_slow_src_sel <= 1'h0;
        done("source");
    endtask
    task automatic t_clear;
        arm(2'h3);
        slow(100, 2'h1);
        apb(1'h1, 12'h3E0, 32'h41);
        rd(12'h3E0, 32'h01);
        slow(127, 2'h1);
        `CHK("after clear", 1'h0, o_tb_flag)
        slow(1, 2'h1);
        `CHK("full period", 1'h1, o_tb_flag)
        done("clear");
    endtask
    // flag still set from the previous scenario
    task automatic t_irq;
        `CHK("irq masked", 1'h0, o_irq)
        rd(12'h380, 32'h1);
        apb(1'h1, 12'h384, 32'h1);
        `CHK("irq on", 1'h1, o_irq)
        apb(1'h1, 12'h380, 32'h1);
        `CHK("irq cleared", 1'h0, o_irq)
        @(posedge i_clk);
        i_tb_isr_enter <= 1'h1;
        @(posedge i_clk);
        i_tb_isr_enter <= 1'h0;
        @(negedge i_clk);
        `CHK("isr clear", 1'h0, o_tb_flag)
        apb(1'h1, 12'h254, 32'h01);
        apb(1'h1, 12'h254, 32'hFE);
        `CHK("FEh clear", 1'h0, o_tb_flag)
        done("irq");
    endtask
    task automatic t_wave0;
        pulse(40, 1'h0);
        `CHK("t0 idle", 1'h0, o_t0_wave_out)
        apb(1'h1, 12'h298, 32'h01);
        `CHK("t0 en", 1'h1, o_t0_wave_en)
        pulse(31, 1'h0);
        `CHK("t0 at 31", 1'h0, o_t0_wave_out)
        pulse(1, 1'h0);
        `CHK("t0 at 32", 1'h1, o_t0_wave_out)
        pulse(32, 1'h0);
        `CHK("t0 at 64", 1'h0, o_t0_wave_out)
        `CHK("t0 rises", 1, r0)
        apb(1'h1, 12'h298, 32'h10);
        `CHK("t0 off", 1'h0, o_t0_wave_en)
        done("wave0");
    endtask
    task automatic t_wave2;
        `CHK("t2 en", 1'h1, o_t2_wave_en)
        @(posedge i_clk);
        i_ce <= 1'h0;
        pulse(2, 1'h1);
        `CHK("t2 frozen", 1'h0, o_t2_wave_out)
        @(posedge i_clk);
        i_ce <= 1'h1;
        pulse(3, 1'h1);
        `CHK("t2 wave", 1'h1, o_t2_wave_out)
        apb(1'h1, 12'h298, 32'h0);
        @(negedge i_clk);
        `CHK("t2 off", 1'h0, o_t2_wave_out)
        `CHK("t2 rises", 2, r2)
        rd(12'h380, 32'h6);
        done("wave2");
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // main sequence; the watchdog allows well over the longest period run
    initial begin
        repeat (8) @(posedge i_clk);
        i_rst <= 1'h0;
        t_reset;
        t_regs;
        t_rates;
        t_source;
        t_clear;
        t_irq;
        t_wave0;
        t_wave2;
        tally_and_finish;
    end
    initial begin
        #470000;
        err_total++;
        tally_and_finish;
    end
endmodule
